// ### core/timer_event_counter.v
`timescale 1ns/1ps
`include "timer_event_counter_map.vh"

module timer_event_counter #(
   parameter CHANNEL = 0
) (
   input  wire        clk_sys,              // System clock
   input  wire        reset_n,              // Asynchronous reset, active low
   input  wire [15:0] bus_addr,             // Register address
   input  wire        bus_wr,               // Write strobe
   input  wire        bus_rd,               // Read strobe
   input  wire [15:0] bus_wdata,            // Write data, bytes in low lane
   output reg  [15:0] bus_rdata,            // Read data, one cycle after strobe
   input  wire        primary_trigger_in,   // Primary trigger pin
   input  wire        secondary_trigger_in, // Secondary trigger pin
   output reg         timer_out,            // Timer output pin
   output reg         first_match_irq,      // First register match pulse
   output reg         second_match_irq      // Second register match pulse
);

   localparam [15:0] A_MODE   = (CHANNEL == 0) ? `MODE_CONTROL_ADDR0 : `MODE_CONTROL_ADDR1;
   localparam [15:0] A_PRESC  = (CHANNEL == 0) ? `PRESCALE_ADDR0 : `PRESCALE_ADDR1;
   localparam [15:0] A_CCCTL  = (CHANNEL == 0) ? `CAPCMP_CONTROL_ADDR0 : `CAPCMP_CONTROL_ADDR1;
   localparam [15:0] A_OUTCTL = (CHANNEL == 0) ? `OUTPUT_CONTROL_ADDR0 : `OUTPUT_CONTROL_ADDR1;
   localparam [15:0] A_COUNT  = (CHANNEL == 0) ? `COUNT_VALUE_ADDR0 : `COUNT_VALUE_ADDR1;
   localparam [15:0] A_FIRST  = (CHANNEL == 0) ? `FIRST_CAPCMP_ADDR0 : `FIRST_CAPCMP_ADDR1;
   localparam [15:0] A_SECOND = (CHANNEL == 0) ? `SECOND_CAPCMP_ADDR0 : `SECOND_CAPCMP_ADDR1;

   reg  [3:0]  mode_control;
   reg  [2:0]  capcmp_control;
   reg         out_enable;
   reg         inv_first;
   reg         inv_second;
   reg  [7:0]  prescale_edge_select;
   reg  [15:0] count_value;
   reg  [15:0] first_capcmp;
   reg  [15:0] second_capcmp;
   reg         out_level;
   reg  [4:0]  prescale_div;
   reg         tick_pending;
   reg         pri_s1;
   reg         pri_s2;
   reg         pri_s3;
   reg         sec_s1;
   reg         sec_s2;
   reg         sec_s3;

   reg  [15:0] next_count;
   reg         next_out_level;
   reg         raw_tick;

   ////////////////////////////////////////////////////////////////////////////////
   // Register strobes

   wire wr_mode   = bus_wr && (bus_addr == A_MODE);
   wire wr_presc  = bus_wr && (bus_addr == A_PRESC);
   wire wr_ccctl  = bus_wr && (bus_addr == A_CCCTL);
   wire wr_outctl = bus_wr && (bus_addr == A_OUTCTL);
   wire wr_first  = bus_wr && (bus_addr == A_FIRST);
   wire wr_second = bus_wr && (bus_addr == A_SECOND);
   wire rd_count  = bus_rd && (bus_addr == A_COUNT);

   ////////////////////////////////////////////////////////////////////////////////
   // Trigger input synchronisers and edge detection

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pri_s1 <= 1'b0;
         pri_s2 <= 1'b0;
         pri_s3 <= 1'b0;
         sec_s1 <= 1'b0;
         sec_s2 <= 1'b0;
         sec_s3 <= 1'b0;
      end else begin
         pri_s1 <= primary_trigger_in;
         pri_s2 <= pri_s1;
         pri_s3 <= pri_s2;
         sec_s1 <= secondary_trigger_in;
         sec_s2 <= sec_s1;
         sec_s3 <= sec_s2;
      end
   end

   wire       pri_rise = pri_s2 & ~pri_s3;
   wire       pri_fall = ~pri_s2 & pri_s3;
   wire       sec_rise = sec_s2 & ~sec_s3;
   wire       sec_fall = ~sec_s2 & sec_s3;
   wire [1:0] pri_es   = prescale_edge_select[`PS_PRI_HI:`PS_PRI_LO];
   wire [1:0] sec_es   = prescale_edge_select[`PS_SEC_HI:`PS_SEC_LO];
   wire [1:0] clk_sel  = prescale_edge_select[`PS_CLK_HI:`PS_CLK_LO];

   // Valid edge per selected code; the prohibited code detects nothing
   wire pri_valid = ((pri_es == `EDGE_FALL) & pri_fall) |
                    ((pri_es == `EDGE_RISE) & pri_rise) |
                    ((pri_es == `EDGE_BOTH) & (pri_rise | pri_fall));
   wire sec_valid = ((sec_es == `EDGE_FALL) & sec_fall) |
                    ((sec_es == `EDGE_RISE) & sec_rise) |
                    ((sec_es == `EDGE_BOTH) & (sec_rise | sec_fall));
   // Inverted phase of the primary valid edge; both-edges yields no capture
   wire pri_inv   = ((pri_es == `EDGE_FALL) & pri_rise) |
                    ((pri_es == `EDGE_RISE) & pri_fall);

   ////////////////////////////////////////////////////////////////////////////////
   // Mode decode

   wire running      = mode_control[`MC_HI] | mode_control[`MC_MID];
   wire edge_clr_md  = mode_control[`MC_HI] & ~mode_control[`MC_MID];
   wire match_clr_md = mode_control[`MC_HI] & mode_control[`MC_MID];
   wire out_match_md = mode_control[`MC_MID];
   wire out_edge_md  = mode_control[`MC_MID] & mode_control[`MC_LO];
   wire first_is_cmp  = ~capcmp_control[`CC_FIRST_CAPTURE];
   wire second_is_cmp = ~capcmp_control[`CC_SECOND_CAPTURE];

   ////////////////////////////////////////////////////////////////////////////////
   // Count clock selection

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         prescale_div <= 5'h00;
      end else begin
         prescale_div <= prescale_div + 5'h01;
      end
   end

   always @* begin
      case (clk_sel)
         `CLK_SEL_FULL:  raw_tick = 1'b1;
         `CLK_SEL_DIV4:  raw_tick = (prescale_div[1:0] == `DIV4_LAST);
         `CLK_SEL_DIV32: raw_tick = (prescale_div == `DIV32_LAST);
         `CLK_SEL_EDGE:  raw_tick = pri_valid;
         default:        raw_tick = 1'b0;
      endcase
   end

   // A counter read holds the count clock off; the held tick is applied afterwards
   wire tick = running & (raw_tick | tick_pending) & ~rd_count;

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         tick_pending <= 1'b0;
      end else begin
         tick_pending <= running & (raw_tick | tick_pending) & rd_count;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Counter

   wire [15:0] count_inc  = count_value + `COUNT_ONE;
   wire        edge_clr   = running & edge_clr_md & pri_valid;
   wire        match_clr  = match_clr_md & (count_value == first_capcmp);
   wire        wrap       = tick & ~edge_clr & (count_value == `COUNT_MAX);

   always @* begin
      next_count = count_value;
      if (!running) begin
         next_count = `COUNT_ZERO;
      end else if (edge_clr) begin
         next_count = `COUNT_ZERO;
      end else if (tick) begin
         if (match_clr) begin
            next_count = `COUNT_ZERO;
         end else begin
            next_count = count_inc;
         end
      end
   end

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         count_value <= `COUNT_ZERO;
      end else begin
         count_value <= next_count;
      end
   end

   // Matches are seen as the counter steps onto the compare value, so zero
   // only matches after a wrap from the top of the range or a match clear
   wire stepped = tick & ~edge_clr;
   wire hit_first  = running & first_is_cmp & stepped &
                     (next_count == first_capcmp);
   wire hit_second = running & second_is_cmp & stepped &
                     (next_count == second_capcmp);

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         first_match_irq  <= 1'b0;
         second_match_irq <= 1'b0;
      end else begin
         first_match_irq  <= hit_first;
         second_match_irq <= hit_second;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Capture/compare registers, no reset value

   wire cap_first  = running & ~first_is_cmp &
                     (capcmp_control[`CC_FIRST_TRIG] ? pri_inv : sec_valid);
   wire cap_second = running & ~second_is_cmp & pri_valid;

   always @(posedge clk_sys) begin
      if (cap_first) begin
         first_capcmp <= count_value;
      end else if (wr_first) begin
         first_capcmp <= bus_wdata;
      end
      if (cap_second) begin
         second_capcmp <= count_value;
      end else if (wr_second) begin
         second_capcmp <= bus_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Control registers

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         mode_control         <= `MC_RESET;
         capcmp_control       <= `CC_RESET;
         prescale_edge_select <= `PS_RESET;
         out_enable           <= 1'b0;
         inv_first            <= 1'b0;
         inv_second           <= 1'b0;
      end else begin
         if (wr_mode) begin
            mode_control[`MC_HI:`MC_LO] <= bus_wdata[`MC_HI:`MC_LO];
         end
         // Overflow set wins over a simultaneous software write
         if (running & wrap) begin
            mode_control[`MC_OVF] <= 1'b1;
         end else if (wr_mode) begin
            mode_control[`MC_OVF] <= bus_wdata[`MC_OVF];
         end
         if (wr_ccctl) begin
            capcmp_control <= bus_wdata[`CC_SECOND_CAPTURE:`CC_FIRST_CAPTURE];
         end
         if (wr_presc) begin
            prescale_edge_select[`PS_SEC_HI:`PS_PRI_LO] <= bus_wdata[`PS_SEC_HI:`PS_PRI_LO];
            prescale_edge_select[`PS_CLK_HI:`PS_CLK_LO] <= bus_wdata[`PS_CLK_HI:`PS_CLK_LO];
         end
         if (wr_outctl) begin
            out_enable <= bus_wdata[`OC_ENABLE];
            inv_first  <= bus_wdata[`OC_INV_FIRST];
            inv_second <= bus_wdata[`OC_INV_SECOND];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Timer output flip-flop

   always @* begin
      next_out_level = out_level;
      if (wr_outctl && bus_wdata[`OC_LV_SET] && !bus_wdata[`OC_LV_RESET]) begin
         next_out_level = 1'b1;
      end else if (wr_outctl && bus_wdata[`OC_LV_RESET] && !bus_wdata[`OC_LV_SET]) begin
         next_out_level = 1'b0;
      end else if (running && out_match_md) begin
         // Simultaneous causes each invert once
         next_out_level = out_level ^ (hit_first & inv_first) ^
                          (hit_second & inv_second) ^
                          (out_edge_md & pri_valid);
      end
   end

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         out_level <= 1'b0;
         timer_out <= 1'b0;
      end else begin
         out_level <= next_out_level;
         timer_out <= out_enable & next_out_level;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read data

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         bus_rdata <= 16'h0000;
      end else if (bus_rd) begin
         case (bus_addr)
            A_MODE:   bus_rdata <= {12'h000, mode_control};
            A_CCCTL:  bus_rdata <= {13'h0000, capcmp_control};
            A_PRESC:  bus_rdata <= {8'h00, prescale_edge_select};
            A_OUTCTL: bus_rdata <= {11'h000, inv_second, 2'h0, inv_first, out_enable};
            A_COUNT:  bus_rdata <= count_value;
            A_FIRST:  bus_rdata <= first_capcmp;
            A_SECOND: bus_rdata <= second_capcmp;
            default:  bus_rdata <= 16'h0000;
         endcase
      end
   end

endmodule

// ### inc/timer_event_counter_map.vh
// Summary of operation
// - 16-bit read-only counter advances once per selected count clock tick.
// - Reading the running counter defers the count tick and returns the held value.
// - Counter clears on reset, stop mode, edge clear mode edge, match clear mode match.
// - Capture/compare control bit 0 makes first register compare or capture.
// - Capture/compare control bit 2 makes second register compare or capture.
// - First register compares continuously; equality raises first match interrupt.
// - Second register compares continuously; equality raises second match interrupt.
// - First register on primary input captures on inverted edge; both-edges captures nothing.
// - First register on secondary input captures on that input's selected edge.
// - Second register captures only on the primary input's selected edge.
// - Capture/compare registers have no reset value; written as 16-bit words.
// - A zero compare value matches only after the counter wraps from FFFF or is cleared by a match.
// - Compare value below count: counter keeps counting, wraps, restarts from zero.
// - Mode 00x stop, 01x free-run, 10x edge clear-start, 11x match clear-start.
// - Output toggles on matches in modes x1x; modes 011/111 also on primary edge.
// - Match interrupts occur in every running mode, never in stop mode.
// - Counting starts when upper mode bits are nonzero, stops when both zero.
// - Mode control bit 0 is the overflow flag, one meaning overflow seen.
// - Match clear mode with first register FFFF sets overflow on wrap to zero.
// - Mode control resets to 00; its upper twelve bits read zero.
// - Capture-trigger bit: 0 secondary valid edge, 1 inverted primary valid edge.
// - Edge select codes: 00 falling, 01 rising, 11 both, 10 prohibited.
`ifndef TIMER_EVENT_COUNTER_MAP_VH
`define TIMER_EVENT_COUNTER_MAP_VH

// Register addresses, channel 0 and channel 1
`define MODE_CONTROL_ADDR0      16'hFF60
`define MODE_CONTROL_ADDR1      16'hFF68
`define PRESCALE_ADDR0          16'hFF61
`define PRESCALE_ADDR1          16'hFF69
`define CAPCMP_CONTROL_ADDR0    16'hFF62
`define CAPCMP_CONTROL_ADDR1    16'hFF6A
`define OUTPUT_CONTROL_ADDR0    16'hFF63
`define OUTPUT_CONTROL_ADDR1    16'hFF6B
`define COUNT_VALUE_ADDR0       16'hFF10
`define COUNT_VALUE_ADDR1       16'hFF16
`define FIRST_CAPCMP_ADDR0      16'hFF12
`define FIRST_CAPCMP_ADDR1      16'hFF18
`define SECOND_CAPCMP_ADDR0     16'hFF14
`define SECOND_CAPCMP_ADDR1     16'hFF1A

// Mode control fields
`define MC_OVF                  0
`define MC_LO                   1
`define MC_MID                  2
`define MC_HI                   3
`define MC_RESET                4'h0

// Capture/compare control fields
`define CC_FIRST_CAPTURE        0
`define CC_FIRST_TRIG           1
`define CC_SECOND_CAPTURE       2
`define CC_RESET                3'h0

// Output control fields
`define OC_ENABLE               0
`define OC_INV_FIRST            1
`define OC_LV_RESET             2
`define OC_LV_SET               3
`define OC_INV_SECOND           4

// Prescale and edge select fields
`define PS_CLK_LO               0
`define PS_CLK_HI               1
`define PS_PRI_LO               4
`define PS_PRI_HI               5
`define PS_SEC_LO               6
`define PS_SEC_HI               7
`define PS_RESET                8'h00

// Count clock selections and edge codes
`define CLK_SEL_FULL            2'h0
`define CLK_SEL_DIV4            2'h1
`define CLK_SEL_DIV32           2'h2
`define CLK_SEL_EDGE            2'h3
`define DIV4_LAST               5'h03
`define DIV32_LAST              5'h1F
`define EDGE_FALL               2'h0
`define EDGE_RISE               2'h1
`define EDGE_BOTH               2'h3

`define COUNT_ZERO              16'h0000
`define COUNT_MAX               16'hFFFF
`define COUNT_ONE               16'h0001

`endif

// ### sim/timer_event_counter_asserts.sv
`timescale 1ns/1ps
`include "timer_event_counter_map.vh"
module timer_event_counter_asserts #(
   parameter CHANNEL = 0
) (
   input wire        clk_sys,              // System clock
   input wire        reset_n,              // Reset, active low
   input wire [15:0] bus_addr,             // Register address
   input wire        bus_wr,               // Write strobe
   input wire        bus_rd,               // Read strobe
   input wire [15:0] bus_wdata,            // Write data
   input wire [15:0] bus_rdata,            // Read data
   input wire        primary_trigger_in,   // Primary trigger pin
   input wire        secondary_trigger_in, // Secondary trigger pin
   input wire        timer_out,            // Timer output pin
   input wire        first_match_irq,      // First match pulse
   input wire        second_match_irq      // Second match pulse
);
   localparam [15:0] MC_A = CHANNEL ? `MODE_CONTROL_ADDR1 : `MODE_CONTROL_ADDR0;
   localparam [15:0] CC_A = CHANNEL ? `CAPCMP_CONTROL_ADDR1 : `CAPCMP_CONTROL_ADDR0;
   localparam [15:0] OC_A = CHANNEL ? `OUTPUT_CONTROL_ADDR1 : `OUTPUT_CONTROL_ADDR0;
   reg [1:0] mode_hi;
   reg       out_en;
   wire      stopped = (mode_hi == 2'h0);
   // Shadow of the run bits and output enable, taken from bus writes
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         mode_hi <= 2'h0;
         out_en  <= 1'b0;
      end else if (bus_wr) begin
         if (bus_addr == MC_A) mode_hi <= bus_wdata[3:2];
         if (bus_addr == OC_A) out_en <= bus_wdata[0];
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   property p_reset_quiet;
      $rose(reset_n) |-> bus_rdata == 16'h0000 && !timer_out && !first_match_irq
         && !second_match_irq;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not idle at reset");
   property p_unmapped;
      bus_rd && bus_addr[15:8] != 8'hFF |=> bus_rdata == 16'h0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_mode_upper;
      bus_rd && bus_addr == MC_A |=> bus_rdata[15:4] == 12'h000;
   endproperty
   a_mode_upper: assert property (p_mode_upper) else $error("mode upper bits set");
   property p_capcmp_upper;
      bus_rd && bus_addr == CC_A |=> bus_rdata[15:3] == 13'h0000;
   endproperty
   a_capcmp_upper: assert property (p_capcmp_upper) else $error("capcmp ctl bits");
   property p_out_ctl_bits;
      bus_rd && bus_addr == OC_A |=> bus_rdata[15:5] == 11'h000 && bus_rdata[3:2] == 2'h0;
   endproperty
   a_out_ctl_bits: assert property (p_out_ctl_bits) else $error("out ctl bits");
   property p_rdata_hold;
      !bus_rd |=> $stable(bus_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
   property p_first_pulse;
      first_match_irq |=> !first_match_irq;
   endproperty
   a_first_pulse: assert property (p_first_pulse) else $error("first irq too long");
   property p_second_pulse;
      second_match_irq |=> !second_match_irq;
   endproperty
   a_second_pulse: assert property (p_second_pulse) else $error("second irq too long");
   property p_stop_quiet;
      stopped [*3] |-> !first_match_irq && !second_match_irq;
   endproperty
   a_stop_quiet: assert property (p_stop_quiet) else $error("irq while stopped");
   property p_out_off;
      !out_en [*2] |-> !timer_out;
   endproperty
   a_out_off: assert property (p_out_off) else $error("output while disabled");
   c_first: cover property (first_match_irq);
   c_second: cover property (second_match_irq);
   c_out: cover property ($rose(timer_out));
endmodule
bind timer_event_counter timer_event_counter_asserts #(.CHANNEL(CHANNEL)) chk_inst (.*);

// ### sim/timer_event_counter_tb.sv
`timescale 1ns/1ps
`include "timer_event_counter_map.vh"
`define CHECK(nm, exp, got) begin cmp_count = cmp_count + 1; if ((got) !== (exp)) begin \
   err_count = err_count + 1; $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module timer_event_counter_tb;
   reg         clk_sys;
   reg         reset_n;
   reg  [15:0] bus_addr;
   reg         bus_wr;
   reg         bus_rd;
   reg  [15:0] bus_wdata;
   wire [15:0] bus_rdata;
   wire        primary_trigger_in;
   wire        secondary_trigger_in;
   wire        timer_out;
   wire        first_match_irq;
   wire        second_match_irq;
   integer     err_count;
   integer     cmp_count;
   integer     i;
   integer     n;
   reg  [15:0] v0;
   reg  [15:0] v1;
   reg  [15:0] v2;
   reg  [15:0] rst_addr [0:5];
   timer_event_counter #(.CHANNEL(0)) timer_event_counter_inst (.*);
   trigger_source trigger_source_inst (.*);
   initial clk_sys = 1'b0;
   always #2 clk_sys = ~clk_sys;
   ////////////////////////////////////////////////////////////////////////
   task wr(input [15:0] a, input [15:0] d);
      begin
         @(posedge clk_sys);
         bus_addr  <= a;
         bus_wdata <= d;
         bus_wr    <= 1'b1;
         @(posedge clk_sys);
         bus_wr    <= 1'b0;
      end
   endtask
   task rd(input [15:0] a, output [15:0] d);
      begin
         @(posedge clk_sys);
         bus_addr <= a;
         bus_rd   <= 1'b1;
         @(posedge clk_sys);
         bus_rd   <= 1'b0;
         #1;
         d = bus_rdata;
      end
   endtask
   // Cycles waited are returned; interval between pulses is n + 1
   task wait_irq(input sel, output integer k);
      begin
         k = 0;
         @(posedge clk_sys);
         #1;
         while ((sel ? second_match_irq : first_match_irq) !== 1'b1 && k < 300) begin
            @(posedge clk_sys);
            #1;
            k = k + 1;
         end
         if (k >= 300) begin
            err_count = err_count + 1;
            $display("[ERR] irq wait ran out");
            final_report;
         end
      end
   endtask
   task final_report;
      begin
         $display("compares %0d mismatches %0d", cmp_count, err_count);
         if (err_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
         end else begin
            $display("Regression broken");
         end
         $finish;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      err_count = 0;
      cmp_count = 0;
      reset_n   = 1'b0;
      bus_addr  = 16'h0000;
      bus_wr    = 1'b0;
      bus_rd    = 1'b0;
      bus_wdata = 16'h0000;
      rst_addr[0] = `MODE_CONTROL_ADDR0;
      rst_addr[1] = `PRESCALE_ADDR0;
      rst_addr[2] = `CAPCMP_CONTROL_ADDR0;
      rst_addr[3] = `OUTPUT_CONTROL_ADDR0;
      rst_addr[4] = `COUNT_VALUE_ADDR0;
      rst_addr[5] = 16'h0000;
      repeat (5) @(posedge clk_sys);
      reset_n <= 1'b1;
      for (i = 0; i < 6; i = i + 1) begin
         rd(rst_addr[i], v0);
         `CHECK("reset value", 16'h0000, v0)
      end
      $display("test reset done");
      wr(`FIRST_CAPCMP_ADDR0, 16'h0005);
      wr(`SECOND_CAPCMP_ADDR0, 16'h0008);
      wr(`OUTPUT_CONTROL_ADDR0, 16'h0013);
      wr(`MODE_CONTROL_ADDR0, 16'h0004);
      wait_irq(1'b0, n);
      `CHECK("out after first", 1'b1, timer_out)
      wait_irq(1'b1, n);
      `CHECK("match gap", 2, n)
      `CHECK("out after second", 1'b0, timer_out)
      rd(`FIRST_CAPCMP_ADDR0, v0);
      `CHECK("first value", 16'h0005, v0)
      rd(`SECOND_CAPCMP_ADDR0, v0);
      `CHECK("second value", 16'h0008, v0)
      wr(`MODE_CONTROL_ADDR0, 16'h0000);
      rd(`COUNT_VALUE_ADDR0, v0);
      `CHECK("count stopped", 16'h0000, v0)
      $display("test interval done");
      wr(`FIRST_CAPCMP_ADDR0, 16'h0003);
      wr(`SECOND_CAPCMP_ADDR0, 16'h0002);
      wr(`MODE_CONTROL_ADDR0, 16'h000C);
      wait_irq(1'b0, n);
      wait_irq(1'b0, n);
      `CHECK("match clear period", 3, n)
      wr(`MODE_CONTROL_ADDR0, 16'h0000);
      $display("test match clear done");
      wr(`CAPCMP_CONTROL_ADDR0, 16'h0007);
      wr(`PRESCALE_ADDR0, 16'h0010);
      wr(`MODE_CONTROL_ADDR0, 16'h0004);
      trigger_source_inst.pulse(1'b0, 10);
      repeat (6) @(posedge clk_sys);
      rd(`FIRST_CAPCMP_ADDR0, v0);
      rd(`SECOND_CAPCMP_ADDR0, v1);
      `CHECK("capture width", 16'd10, v0 - v1)
      wr(`MODE_CONTROL_ADDR0, 16'h0000);
      wr(`PRESCALE_ADDR0, 16'h0030);
      wr(`MODE_CONTROL_ADDR0, 16'h0004);
      trigger_source_inst.pulse(1'b0, 10);
      repeat (6) @(posedge clk_sys);
      rd(`FIRST_CAPCMP_ADDR0, v1);
      `CHECK("both edges no capture", v0, v1)
      wr(`MODE_CONTROL_ADDR0, 16'h0000);
      rd(`SECOND_CAPCMP_ADDR0, v1);
      wr(`CAPCMP_CONTROL_ADDR0, 16'h0005);
      wr(`PRESCALE_ADDR0, 16'h0040);
      wr(`MODE_CONTROL_ADDR0, 16'h0004);
      trigger_source_inst.pulse(1'b1, 8);
      repeat (6) @(posedge clk_sys);
      rd(`FIRST_CAPCMP_ADDR0, v2);
      `CHECK("secondary captured", 1'b1, v2 != v0)
      rd(`SECOND_CAPCMP_ADDR0, v0);
      `CHECK("second ignores secondary", v1, v0)
      $display("test capture done");
      wr(`MODE_CONTROL_ADDR0, 16'h0000);
      wr(`CAPCMP_CONTROL_ADDR0, 16'h0000);
      wr(`FIRST_CAPCMP_ADDR0, 16'hFFFF);
      wr(`SECOND_CAPCMP_ADDR0, 16'h0001);
      wr(`MODE_CONTROL_ADDR0, 16'h000C);
      v0 = 16'h0000;
      for (i = 0; i < 40000 && v0[0] !== 1'b1; i = i + 1) rd(`MODE_CONTROL_ADDR0, v0);
      `CHECK("overflow flag", 16'h000D, v0)
      $display("test overflow done");
      final_report;
   end
endmodule

// ### sim/trigger_source.sv
`timescale 1ns/1ps
module trigger_source (
   input  wire clk_sys,              // System clock
   input  wire timer_out,            // Timer output load
   output reg  primary_trigger_in,   // Primary trigger drive
   output reg  secondary_trigger_in  // Secondary trigger drive
);
   initial begin
      primary_trigger_in   = 1'b0;
      secondary_trigger_in = 1'b0;
   end
   // Pulses last whole cycles, well above two count-clock periods
   task pulse(input sel, input integer w);
      begin
         @(posedge clk_sys);
         if (sel) secondary_trigger_in <= 1'b1;
         else primary_trigger_in <= 1'b1;
         repeat (w) @(posedge clk_sys);
         secondary_trigger_in <= 1'b0;
         primary_trigger_in   <= 1'b0;
      end
   endtask
endmodule
